//--- inc/ivfs_pkg.sv
// Purpose: Constants, types and the threshold decoder for the input-voltage fault supervisor.
// Assumes: Measured input voltage arrives as an unsigned fixed-point word, LSB = 1/256 V.
// Notes:   Command codes are the register offsets seen by the command port.
`default_nettype none
package ivfs_pkg;

	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_OV_FAULT_TH = 8'h55;
	localparam logic [7:0] CMD_OV_FAULT_ACT = 8'h56;
	localparam logic [7:0] CMD_OV_WARN_TH = 8'h57;
	localparam logic [7:0] CMD_UV_WARN_TH = 8'h58;
	localparam logic [7:0] CMD_UV_FAULT_TH = 8'h59;
	localparam logic [7:0] CMD_UV_FAULT_ACT = 8'h5a;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_OV_FAULT_TH = 16'hd3a0;
	localparam logic [15:0] RST_OV_WARN_TH = 16'hd34d;
	localparam logic [15:0] RST_UV_WARN_TH = 16'hca30;
	localparam logic [15:0] RST_UV_FAULT_TH = 16'hca00;
	localparam logic [7:0] RST_FAULT_ACT = 8'h80;

	// ****************************************
	// Accepted threshold ranges, in 1/256 V
	// ****************************************
	localparam int FIX_FRAC_BITS = 8;
	localparam logic signed [31:0] MAX_OV_FAULT_FIX = 32'sh0000_1000;
	localparam logic signed [31:0] MAX_WARN_FIX = 32'sh0000_1300;
	localparam logic signed [31:0] MAX_UV_FAULT_FIX = 32'sh0000_0c00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int ACT_BEH_HI = 7;
	localparam int ACT_BEH_LO = 6;
	localparam int ACT_RETRY_HI = 5;
	localparam int ACT_RETRY_LO = 3;
	localparam int ACT_TIME_HI = 2;
	localparam int ACT_TIME_LO = 0;
	localparam int SI_OV_FAULT = 7;
	localparam int SI_OV_WARN = 6;
	localparam int SI_UV_WARN = 5;
	localparam int SI_UV_FAULT = 4;
	localparam int SW_INPUT = 13;
	localparam int SB_OFF = 6;
	localparam int SB_UV_FAULT = 3;
	localparam int SB_CATCH_ALL = 0;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 200;
	localparam int OV_TIME_UNIT_US = 1000;
	localparam int UV_TIME_UNIT_US = 1000;
	localparam int OV_UNIT_CYC = OV_TIME_UNIT_US * CLK_MHZ;
	localparam int UV_UNIT_CYC = UV_TIME_UNIT_US * CLK_MHZ;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		BEH_IGNORE = 2'b00,
		BEH_DELAY = 2'b01,
		BEH_OFF = 2'b10,
		BEH_HOLD = 2'b11
	} ivfs_beh_e;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_DELAY = 3'b001,
		ST_OFF = 3'b010,
		ST_WAIT = 3'b011,
		ST_HOLD = 3'b100,
		ST_LATCH = 3'b101
	} ivfs_state_e;

	// Linear word to 1/256 V fixed point: 5-bit exponent, 11-bit mantissa
	function automatic logic signed [31:0] ivfs_linear_to_fix(input logic [15:0] w);
		logic signed [5:0] sh;
		logic signed [31:0] m;
		sh = $signed({w[15], w[15:11]}) + 6'sd8;
		m = {{21{w[10]}}, w[10:0]};
		if (sh >= 0) begin
			return m <<< sh[4:0];
		end
		return m >>> 6'(-sh);
	endfunction : ivfs_linear_to_fix

endpackage : ivfs_pkg
`default_nettype wire

//--- core/ivfs_core.sv
// Purpose: Input overvoltage / undervoltage supervision with fault-response engine.
// Assumes: Command port is already decoded from the bus; vin is synchronous to sys_clk_in.
// Notes:   Channel 0 handles overvoltage, channel 1 undervoltage.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Overvoltage fault threshold word, resets to 14.5 V, accepts 0 to 16 V.
// - Each fault action byte resets to disable with no retry.
// - Behaviour 00 keeps the output running despite the fault.
// - Behaviour 01 waits the time field, then disables and retries.
// - Behaviour 10 disables at once, then retries per retry field.
// - Behaviour 11 holds output off while fault persists, then re-enables.
// - Fault status bits stay set until the clear-faults command.
// - Retry field 000 latches the output off until device restart.
// - Retry field 1 to 6 gives that many restarts spaced by time field.
// - Retry field 111 restarts forever without checking the fault.
// - Time field sets both response delay and retry spacing, unit per fault type.
// - Overvoltage warning sets catch-all, input summary, warning bit, and alerts.
// - Undervoltage warning sets catch-all, input summary, warning bit, and alerts.
// - Undervoltage fault stays active until input exceeds the warning threshold.
// - Overvoltage warning threshold word resets to 13.2 V, accepts 0 to 19 V.
// - Undervoltage warning threshold word resets to 4.38 V.
// - Undervoltage fault threshold word resets to 4 V, accepts 0 to 12 V.
// - Thresholds move as two-byte linear words over word transactions.
// - Status word bit 13 summarises every input fault or warning.
// - Undervoltage fault shows in bit 3 of status byte and word.
module ivfs_core
	import ivfs_pkg::*;
#(
	parameter int OV_UNIT_CYCLES = OV_UNIT_CYC,
	parameter int UV_UNIT_CYCLES = UV_UNIT_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [15:0] vin_fix_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic wr_strobe_in,
	input wire logic [15:0] wr_data_in,
	input wire logic rd_strobe_in,
	output logic [15:0] rd_data_out,
	output logic rd_valid_out,
	output logic alert_n_out,
	output logic out_enable_out
);

	// ****************************************
	// Command registers
	// ****************************************
	logic [15:0] input_overvolt_fault_threshold_reg, input_overvolt_fault_threshold_next;
	logic [15:0] input_overvolt_warning_threshold_reg, input_overvolt_warning_threshold_next;
	logic [15:0] input_undervolt_warning_threshold_reg, input_undervolt_warning_threshold_next;
	logic [15:0] input_undervolt_fault_threshold_reg, input_undervolt_fault_threshold_next;
	logic [7:0] input_overvolt_fault_action_reg, input_overvolt_fault_action_next;
	logic [7:0] input_undervolt_fault_action_reg, input_undervolt_fault_action_next;
	logic signed [31:0] wr_fix, ovf_fix, ovw_fix, uvw_fix, uvf_fix, vin_fix;
	logic clear_faults;
	assign wr_fix = ivfs_linear_to_fix(wr_data_in);
	assign clear_faults = wr_strobe_in && (cmd_code_in == CMD_CLEAR_FAULTS);
	always_comb begin
		input_overvolt_fault_threshold_next = input_overvolt_fault_threshold_reg;
		input_overvolt_warning_threshold_next = input_overvolt_warning_threshold_reg;
		input_undervolt_warning_threshold_next = input_undervolt_warning_threshold_reg;
		input_undervolt_fault_threshold_next = input_undervolt_fault_threshold_reg;
		input_overvolt_fault_action_next = input_overvolt_fault_action_reg;
		input_undervolt_fault_action_next = input_undervolt_fault_action_reg;
		if (wr_strobe_in) begin
			case (cmd_code_in)
				CMD_OV_FAULT_TH: begin
					if (wr_fix >= 0 && wr_fix <= MAX_OV_FAULT_FIX) begin
						input_overvolt_fault_threshold_next = wr_data_in;
					end
				end
				CMD_OV_WARN_TH: begin
					if (wr_fix >= 0 && wr_fix <= MAX_WARN_FIX) begin
						input_overvolt_warning_threshold_next = wr_data_in;
					end
				end
				CMD_UV_WARN_TH: begin
					if (wr_fix >= 0 && wr_fix <= MAX_WARN_FIX) begin
						input_undervolt_warning_threshold_next = wr_data_in;
					end
				end
				CMD_UV_FAULT_TH: begin
					if (wr_fix >= 0 && wr_fix <= MAX_UV_FAULT_FIX) begin
						input_undervolt_fault_threshold_next = wr_data_in;
					end
				end
				CMD_OV_FAULT_ACT: input_overvolt_fault_action_next = wr_data_in[7:0];
				CMD_UV_FAULT_ACT: input_undervolt_fault_action_next = wr_data_in[7:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			input_overvolt_fault_threshold_reg <= RST_OV_FAULT_TH;
			input_overvolt_warning_threshold_reg <= RST_OV_WARN_TH;
			input_undervolt_warning_threshold_reg <= RST_UV_WARN_TH;
			input_undervolt_fault_threshold_reg <= RST_UV_FAULT_TH;
			input_overvolt_fault_action_reg <= RST_FAULT_ACT;
			input_undervolt_fault_action_reg <= RST_FAULT_ACT;
		end else begin
			input_overvolt_fault_threshold_reg <= input_overvolt_fault_threshold_next;
			input_overvolt_warning_threshold_reg <= input_overvolt_warning_threshold_next;
			input_undervolt_warning_threshold_reg <= input_undervolt_warning_threshold_next;
			input_undervolt_fault_threshold_reg <= input_undervolt_fault_threshold_next;
			input_overvolt_fault_action_reg <= input_overvolt_fault_action_next;
			input_undervolt_fault_action_reg <= input_undervolt_fault_action_next;
		end
	end
	a_ovf_range: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		ovf_fix >= 0 && ovf_fix <= MAX_OV_FAULT_FIX) else $error("ov fault threshold out of range");
	a_uvf_range: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		uvf_fix >= 0 && uvf_fix <= MAX_UV_FAULT_FIX) else $error("uv fault threshold out of range");
	a_ovw_range: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		ovw_fix >= 0 && ovw_fix <= MAX_WARN_FIX) else $error("ov warn threshold out of range");
	// ****************************************
	// Threshold comparison
	// ****************************************
	logic ov_fault_now, ov_warn_now, uv_warn_now, uv_below_fault;
	logic uv_active_reg, uv_active_next;
	assign ovf_fix = ivfs_linear_to_fix(input_overvolt_fault_threshold_reg);
	assign ovw_fix = ivfs_linear_to_fix(input_overvolt_warning_threshold_reg);
	assign uvw_fix = ivfs_linear_to_fix(input_undervolt_warning_threshold_reg);
	assign uvf_fix = ivfs_linear_to_fix(input_undervolt_fault_threshold_reg);
	assign vin_fix = $signed({16'h0000, vin_fix_in});
	assign ov_fault_now = vin_fix > ovf_fix;
	assign uv_below_fault = vin_fix < uvf_fix;
	assign ov_warn_now = vin_fix > ovw_fix;
	assign uv_warn_now = vin_fix < uvw_fix;
	always_comb begin
		uv_active_next = uv_below_fault || (uv_active_reg && !(vin_fix > uvw_fix));
	end
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			uv_active_reg <= 1'b0;
		end else begin
			uv_active_reg <= uv_active_next;
		end
	end
	a_uv_hyst: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(uv_active_reg && !(vin_fix > uvw_fix)) |=> uv_active_reg)
		else $error("uv fault released early");
	// ****************************************
	// Response engine, one per fault type
	// ****************************************
	logic [1:0] fault_now;
	logic [7:0] act [2];
	logic [31:0] unit_cyc [2];
	logic [1:0] ch_on;
	assign fault_now = {uv_active_reg, ov_fault_now};
	assign act[0] = input_overvolt_fault_action_reg;
	assign act[1] = input_undervolt_fault_action_reg;
	assign unit_cyc[0] = 32'(OV_UNIT_CYCLES);
	assign unit_cyc[1] = 32'(UV_UNIT_CYCLES);
	for (genvar c = 0; c < 2; c++) begin : g_ch
		ivfs_state_e st_reg, st_next;
		logic [2:0] try_reg, try_next;
		logic [31:0] tmr_reg, tmr_next, span;
		logic [2:0] retry;
		assign retry = act[c][ACT_RETRY_HI:ACT_RETRY_LO];
		assign span = 32'(act[c][ACT_TIME_HI:ACT_TIME_LO] * unit_cyc[c]);
		assign ch_on[c] = (st_reg == ST_RUN) || (st_reg == ST_DELAY);
		always_comb begin
			st_next = st_reg;
			try_next = try_reg;
			tmr_next = (tmr_reg != 32'h0) ? tmr_reg - 32'h1 : 32'h0;
			case (st_reg)
				ST_RUN: begin
					if (!fault_now[c]) begin
						try_next = 3'h0;
					end else begin
						case (act[c][ACT_BEH_HI:ACT_BEH_LO])
							BEH_DELAY: begin
								st_next = ST_DELAY;
								tmr_next = span;
							end
							BEH_OFF: st_next = ST_OFF;
							BEH_HOLD: st_next = ST_HOLD;
							default: ;
						endcase
					end
				end
				ST_DELAY: begin
					if (!fault_now[c]) begin
						st_next = ST_RUN;
					end else if (tmr_reg == 32'h0) begin
						st_next = ST_OFF;
					end
				end
				ST_OFF: begin
					if (retry == RETRY_NONE) begin
						st_next = ST_LATCH;
					end else if (retry == RETRY_FOREVER) begin
						st_next = ST_WAIT;
						tmr_next = span;
					end else if (try_reg < retry) begin
						st_next = ST_WAIT;
						tmr_next = span;
						try_next = 3'(try_reg + 3'h1);
					end else begin
						st_next = ST_LATCH;
					end
				end
				ST_WAIT: begin
					if (tmr_reg == 32'h0) begin
						st_next = ST_RUN;
					end
				end
				ST_HOLD: begin
					if (!fault_now[c]) begin
						st_next = ST_RUN;
					end
				end
				ST_LATCH: ;
				default: st_next = ST_RUN;
			endcase
		end
		always_ff @(posedge sys_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				st_reg <= ST_RUN;
				try_reg <= 3'h0;
				tmr_reg <= 32'h0;
			end else begin
				st_reg <= st_next;
				try_reg <= try_next;
				tmr_reg <= tmr_next;
			end
		end
		a_ignore_run: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
			(st_reg == ST_RUN && act[c][7:6] == 2'b00) |=> st_reg == ST_RUN)
			else $error("ignored fault changed state");
		a_immediate_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
			(st_reg == ST_RUN && fault_now[c] && act[c][7:6] == 2'b10) |=> !ch_on[c])
			else $error("output not disabled at once");
		a_hold_release: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
			(st_reg == ST_HOLD && !fault_now[c]) |=> ch_on[c]) else $error("hold not released");
		a_no_retry: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
			(st_reg == ST_OFF && retry == 3'h0) |=> st_reg == ST_LATCH ##1 st_reg == ST_LATCH)
			else $error("retry attempted with none set");
	end
	// ****************************************
	// Sticky status and alert
	// ****************************************
	logic [7:0] status_input_reg, status_input_next, status_set;
	logic [7:0] status_byte;
	logic [15:0] status_word;
	logic alert_n_reg, alert_n_next;
	logic out_enable_reg, out_enable_next;
	always_comb begin
		status_set = 8'h00;
		status_set[SI_OV_FAULT] = ov_fault_now;
		status_set[SI_OV_WARN] = ov_warn_now;
		status_set[SI_UV_WARN] = uv_warn_now;
		status_set[SI_UV_FAULT] = uv_active_reg;
		status_input_next = (clear_faults ? 8'h00 : status_input_reg) | status_set;
		alert_n_next = !(|status_input_reg);
		out_enable_next = &ch_on;
	end
	always_comb begin
		status_byte = 8'h00;
		status_byte[SB_OFF] = !out_enable_reg;
		status_byte[SB_UV_FAULT] = status_input_reg[SI_UV_FAULT];
		status_byte[SB_CATCH_ALL] = status_input_reg[SI_OV_WARN] | status_input_reg[SI_UV_WARN]
			| status_input_reg[SI_OV_FAULT];
		status_word = {8'h00, status_byte};
		status_word[SW_INPUT] = |status_input_reg;
	end
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_input_reg <= 8'h00;
			alert_n_reg <= 1'b1;
			out_enable_reg <= 1'b1;
		end else begin
			status_input_reg <= status_input_next;
			alert_n_reg <= alert_n_next;
			out_enable_reg <= out_enable_next;
		end
	end
	assign alert_n_out = alert_n_reg;
	assign out_enable_out = out_enable_reg;
	a_status_sticky: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		!clear_faults |=> (status_input_reg & $past(status_input_reg)) == $past(status_input_reg))
		else $error("fault bit lost without clear");
	a_ovw_alert: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		ov_warn_now |=> status_input_reg[SI_OV_WARN] && status_word[SW_INPUT]
		&& status_byte[SB_CATCH_ALL] ##1 !alert_n_out)
		else $error("ov warning not reported");
	a_uvw_alert: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		uv_warn_now |=> status_input_reg[SI_UV_WARN] && status_word[SW_INPUT] ##1 !alert_n_out)
		else $error("uv warning not reported");
	a_uvf_bit: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		uv_active_reg |=> status_word[SB_UV_FAULT]) else $error("uv fault bit missing");
	// ****************************************
	// Read path
	// ****************************************
	logic [15:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg;

	always_comb begin
		rd_data_next = rd_data_reg;
		if (rd_strobe_in) begin
			case (cmd_code_in)
				CMD_OV_FAULT_TH: rd_data_next = input_overvolt_fault_threshold_reg;
				CMD_OV_WARN_TH: rd_data_next = input_overvolt_warning_threshold_reg;
				CMD_UV_WARN_TH: rd_data_next = input_undervolt_warning_threshold_reg;
				CMD_UV_FAULT_TH: rd_data_next = input_undervolt_fault_threshold_reg;
				CMD_OV_FAULT_ACT: rd_data_next = {8'h00, input_overvolt_fault_action_reg};
				CMD_UV_FAULT_ACT: rd_data_next = {8'h00, input_undervolt_fault_action_reg};
				CMD_STATUS_BYTE: rd_data_next = {8'h00, status_byte};
				CMD_STATUS_WORD: rd_data_next = status_word;
				CMD_STATUS_INPUT: rd_data_next = {8'h00, status_input_reg};
				default: rd_data_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_data_reg <= 16'h0000;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_strobe_in;
		end
	end

	assign rd_data_out = rd_data_reg;
	assign rd_valid_out = rd_valid_reg;

endmodule : ivfs_core

`default_nettype wire

//--- tb/ivfs_host.sv
// Purpose: Host model that reads and writes commands of the supervisor.
// Assumes: One-cycle strobes; read data comes with the read-valid pulse.
// Notes:   Write data is inverted once released so stale values never look valid.
`timescale 1ns/1ps
`default_nettype none
module ivfs_host (
	input wire logic sys_clk_in,
	output logic [7:0] cmd_code_out,
	output logic wr_strobe_out,
	output logic [15:0] wr_data_out,
	output logic rd_strobe_out,
	input wire logic [15:0] rd_data_in,
	input wire logic rd_valid_in
);
	// ****************************************
	// Command transfers
	// ****************************************
	initial begin
		cmd_code_out = 8'h00;
		wr_strobe_out = 1'b0;
		wr_data_out = 16'h0000;
		rd_strobe_out = 1'b0;
	end

	task automatic write_word(input logic [7:0] code, input logic [15:0] data);
		@(posedge sys_clk_in);
		#1;
		cmd_code_out = code;
		wr_data_out = data;
		wr_strobe_out = 1'b1;
		@(posedge sys_clk_in);
		#1;
		wr_strobe_out = 1'b0;
		wr_data_out = ~data;
	endtask : write_word

	task automatic read_word(input logic [7:0] code, output logic [15:0] data);
		int n;
		@(posedge sys_clk_in);
		#1;
		cmd_code_out = code;
		rd_strobe_out = 1'b1;
		@(posedge sys_clk_in);
		#1;
		rd_strobe_out = 1'b0;
		n = 0;
		while (rd_valid_in !== 1'b1 && n < 4) begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		data = (rd_valid_in === 1'b1) ? rd_data_in : 16'hxxxx;
	endtask : read_word
endmodule : ivfs_host
`default_nettype wire

//--- tb/ivfs_core_test.sv
// Purpose: Self-checking bench for the input-voltage fault supervisor.
// Assumes: Host model drives the command port; the bench drives the voltage.
// Notes:   Time unit shortened to 4 cycles so delays and retries stay short.
`timescale 1ns/1ps
`default_nettype none
module ivfs_core_test import ivfs_pkg::*;;
	localparam int UNIT = 4;
	localparam logic [15:0] V12 = 16'h0c00;
	localparam logic [15:0] V15 = 16'h0f00;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [15:0] vin = 16'h0c00;
	logic [7:0] cmd_code;
	logic wr_strobe;
	logic rd_strobe;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic rd_valid;
	logic alert_n;
	logic out_en;
	int fail_count = 0;
	int cmp_count = 0;
	int rises;
	logic [2:0] retry_tab [3] = '{3'h1, 3'h3, 3'h7};

	always #2.5 sys_clk_in = ~sys_clk_in;

	ivfs_core #(.OV_UNIT_CYCLES(UNIT), .UV_UNIT_CYCLES(UNIT)) uut (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .vin_fix_in(vin),
		.cmd_code_in(cmd_code), .wr_strobe_in(wr_strobe), .wr_data_in(wr_data),
		.rd_strobe_in(rd_strobe), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
		.alert_n_out(alert_n), .out_enable_out(out_en)
	);

	ivfs_host host (
		.sys_clk_in(sys_clk_in), .cmd_code_out(cmd_code), .wr_strobe_out(wr_strobe),
		.wr_data_out(wr_data), .rd_strobe_out(rd_strobe), .rd_data_in(rd_data),
		.rd_valid_in(rd_valid)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
		logic [15:0] d;
		host.read_word(code, d);
		chk(d, exp);
	endtask : rd_chk

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : tick

	task automatic set_vin(input logic [15:0] v);
		tick(1);
		vin = v;
	endtask : set_vin

	task automatic restart;
		tick(1);
		rstn_in = 1'b0;
		vin = V12;
		tick(12);
		rstn_in = 1'b1;
		tick(2);
	endtask : restart

	task automatic count_rises(input int n);
		logic last;
		rises = 0;
		last = out_en;
		repeat (n) begin
			tick(1);
			if (out_en === 1'b1 && last !== 1'b1) rises++;
			last = out_en;
		end
	endtask : count_rises

	task automatic warn_case(input logic [15:0] v, input logic [15:0] si);
		set_vin(v);
		tick(3);
		chk({15'h0, alert_n}, 16'h0000);
		set_vin(V12);
		rd_chk(CMD_STATUS_INPUT, si);
		rd_chk(CMD_STATUS_WORD, 16'h2001);
		host.write_word(CMD_CLEAR_FAULTS, 16'h0000);
		rd_chk(CMD_STATUS_WORD, 16'h0000);
		tick(2);
		chk({15'h0, alert_n}, 16'h0001);
	endtask : warn_case

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		#50000;
		fail_count++;
		$display("ERROR t=%0t watchdog expired", $time);
		close_out();
	end

	initial begin
		tick(12);
		rstn_in = 1'b1;
		tick(2);
		rd_chk(CMD_OV_FAULT_TH, 16'hd3a0);
		rd_chk(CMD_OV_FAULT_ACT, 16'h0080);
		rd_chk(CMD_OV_WARN_TH, 16'hd34d);
		rd_chk(CMD_UV_WARN_TH, 16'hca30);
		rd_chk(CMD_UV_FAULT_TH, 16'hca00);
		rd_chk(CMD_UV_FAULT_ACT, 16'h0080);
		rd_chk(CMD_STATUS_WORD, 16'h0000);
		rd_chk(8'h20, 16'h0000);
		$display("test reset_values done");
		// Exponent -4 words: 16 V and 19 V accepted, 17 V and 13 V refused
		host.write_word(CMD_OV_FAULT_TH, 16'he100);
		rd_chk(CMD_OV_FAULT_TH, 16'he100);
		host.write_word(CMD_OV_FAULT_TH, 16'he110);
		rd_chk(CMD_OV_FAULT_TH, 16'he100);
		host.write_word(CMD_UV_FAULT_TH, 16'he0d0);
		rd_chk(CMD_UV_FAULT_TH, 16'hca00);
		host.write_word(CMD_OV_WARN_TH, 16'he130);
		rd_chk(CMD_OV_WARN_TH, 16'he130);
		host.write_word(CMD_UV_FAULT_ACT, 16'h00c5);
		rd_chk(CMD_UV_FAULT_ACT, 16'h00c5);
		$display("test write_range done");
		restart();
		warn_case(16'h0d40, 16'h0040);
		warn_case(16'h0440, 16'h0020);
		$display("test warnings done");
		host.write_word(CMD_OV_FAULT_ACT, 16'h0000);
		set_vin(V15);
		tick(6);
		chk({15'h0, out_en}, 16'h0001);
		rd_chk(CMD_STATUS_INPUT, 16'h00c0);
		restart();
		set_vin(V15);
		tick(3);
		chk({15'h0, out_en}, 16'h0000);
		rd_chk(CMD_STATUS_BYTE, 16'h0041);
		set_vin(V12);
		tick(20);
		chk({15'h0, out_en}, 16'h0000);
		restart();
		$display("test ignore_and_latch done");
		host.write_word(CMD_OV_FAULT_ACT, 16'h00c0);
		set_vin(V15);
		tick(3);
		chk({15'h0, out_en}, 16'h0000);
		set_vin(V12);
		tick(4);
		chk({15'h0, out_en}, 16'h0001);
		host.write_word(CMD_UV_FAULT_ACT, 16'h00c0);
		set_vin(16'h0300);
		tick(3);
		chk({15'h0, out_en}, 16'h0000);
		rd_chk(CMD_STATUS_BYTE, 16'h0049);
		set_vin(16'h0440);
		tick(6);
		chk({15'h0, out_en}, 16'h0000);
		set_vin(V12);
		tick(4);
		chk({15'h0, out_en}, 16'h0001);
		restart();
		$display("test hold_and_hysteresis done");
		host.write_word(CMD_OV_FAULT_ACT, 16'h0042);
		set_vin(V15);
		tick(5);
		chk({15'h0, out_en}, 16'h0001);
		tick(8);
		chk({15'h0, out_en}, 16'h0000);
		restart();
		$display("test delayed_off done");
		foreach (retry_tab[i]) begin
			host.write_word(CMD_OV_FAULT_ACT, {8'h00, 2'b10, retry_tab[i], 3'h1});
			set_vin(V15);
			count_rises(120);
			if (retry_tab[i] == RETRY_FOREVER) begin
				chk({15'h0, rises > 5}, 16'h0001);
			end else begin
				chk(16'(rises), {13'h0, retry_tab[i]});
			end
			restart();
		end
		$display("test retries done");
		close_out();
	end
endmodule : ivfs_core_test
`default_nettype wire
